// ### tesr_array_model.sv
// behavioural one-entry tlb array behind the staging registers
`timescale 1ns/100ps
module tesr_array_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic tlb_wr_en,
    input wire tesr_pkg::tesr_entry_t tlb_wr_entry,
    output tesr_pkg::tesr_entry_t tlb_rd_entry
);
    tesr_pkg::tesr_entry_t entry_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            entry_reg <= '0;
        end else if (tlb_wr_en) begin
            entry_reg <= tlb_wr_entry;
        end
    end
    assign tlb_rd_entry = entry_reg;
endmodule : tesr_array_model

// ### tesr_pkg.sv
// package for the tlb entry staging register group
package tesr_pkg;
    // ****************************************
    // register selectors (coprocessor numbering)
    // ****************************************
    localparam logic [4:0] REG_EVEN_ENTRY = 5'h02;
    localparam logic [4:0] REG_ODD_ENTRY = 5'h03;
    localparam logic [4:0] REG_PTE_PTR = 5'h04;
    localparam logic [4:0] REG_PAGE_SIZE = 5'h05;
    localparam logic [2:0] SEL_PTE_PTR = 3'h0;
    localparam logic [2:0] SEL_SCRATCH = 3'h2;
    localparam logic [2:0] SEL_PAGE_SIZE = 3'h0;
    localparam logic [2:0] SEL_ZERO = 3'h0;
    localparam logic [4:0] USER_LOCAL_HW_INDEX = 5'h1d;
    // ****************************************
    // entry register fields
    // ****************************************
    localparam int ENT_READ_INH = 31;
    localparam int ENT_EXEC_INH = 30;
    localparam int ENT_PFN_HI = 25;
    localparam int ENT_PFN_LO = 6;
    localparam int ENT_WRITE_EN = 2;
    localparam int ENT_VALID = 1;
    localparam int ENT_GLOBAL = 0;
    localparam logic [31:0] ENT_RW_MASK = 32'h03ff_ffff;
    // ****************************************
    // pointer register fields
    // ****************************************
    localparam logic [31:0] PTE_BASE_MASK = 32'hff80_0000;
    localparam int PTE_MISS_HI = 22;
    localparam int PTE_MISS_LO = 4;
    // ****************************************
    // page size register fields
    // ****************************************
    localparam logic [31:0] PSZ_MASK_FIELD = 32'h1fff_e000;
    localparam logic [31:0] PSZ_EXT_FIELD = 32'h0000_1800;
    localparam logic [1:0] PSZ_EXT_DISABLED = 2'h3;
    localparam int PSZ_EXT_LO = 11;
    // ****************************************
    // granularity bits, hw gate bit
    // ****************************************
    localparam int GRAN_READ_INH_EN = 31;
    localparam int GRAN_EXEC_INH_EN = 30;
    localparam int GRAN_TINY_PAGE_EN = 28;
    localparam int GATE_USER_LOCAL = 29;
    // ****************************************
    // coherency codes
    // ****************************************
    localparam logic [2:0] COH_WT_NOALLOC = 3'h0;
    localparam logic [2:0] COH_WT_ALLOC = 3'h1;
    localparam logic [2:0] COH_UNCACHED = 3'h2;
    localparam logic [2:0] COH_WB_ALLOC = 3'h3;
    localparam logic [2:0] COH_UNCACHED_ALIAS = 3'h7;

    // one tlb entry half as seen by the array
    typedef struct packed {
        logic [19:0] page_frame_number;
        logic [2:0] coherency;
        logic write_en;
        logic valid;
        logic read_inh;
        logic exec_inh;
    } tesr_half_t;

    // entry data moving to or from the array
    typedef struct packed {
        tesr_half_t even;
        tesr_half_t odd;
        logic global_bit;
        logic [17:0] mask;
    } tesr_entry_t;

    // access checked against a matched page half
    typedef struct packed {
        logic fetch;
        logic load;
        logic store;
    } tesr_access_t;
endpackage : tesr_pkg

// ### tesr_regs.sv
// tlb entry staging registers: entry pair, pointer, scratch, page size
`timescale 1ns/100ps

module tesr_regs #(
    parameter bit TINY_PAGE_CAPABLE = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    // coprocessor register moves
    input wire logic mtc_en,
    input wire logic [4:0] mtc_reg,
    input wire logic [2:0] mtc_sel,
    input wire logic [31:0] mtc_data,
    input wire logic [4:0] mfc_reg,
    input wire logic [2:0] mfc_sel,
    output logic [31:0] mfc_data,
    // unprivileged hardware register read
    input wire logic [4:0] hw_rd_index,
    input wire logic [31:0] hw_reg_access_gate,
    output logic hw_rd_ok,
    output logic [31:0] hw_rd_data,
    // granularity control from outside
    input wire logic [31:0] page_granularity_reg,
    // tlb instructions and array
    input wire logic tlb_read_instr,
    input wire tesr_pkg::tesr_entry_t tlb_rd_entry,
    input wire logic tlb_indexed_write,
    input wire logic tlb_random_write,
    output logic tlb_wr_en,
    output tesr_pkg::tesr_entry_t tlb_wr_entry,
    // tlb miss capture
    input wire logic tlb_fault,
    input wire logic [31:0] fault_vaddr,
    // page check for a matched entry half
    input wire tesr_pkg::tesr_half_t chk_half,
    input wire tesr_pkg::tesr_access_t chk_access,
    input wire logic chk_global,
    input wire logic [7:0] chk_entry_asid,
    input wire logic [7:0] chk_cur_asid,
    input wire logic [31:0] chk_vaddr,
    output logic chk_asid_match,
    output logic chk_invalid_fault,
    output logic chk_modified_fault,
    output logic [31:0] chk_paddr,
    output logic [2:0] chk_cache_policy,
    // mask for array matching
    output logic [17:0] match_ignore_ext
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] tesr_half_to_word(input tesr_pkg::tesr_half_t h,
                                                      input logic g);
        tesr_half_to_word = {h.read_inh, h.exec_inh, 4'h0, h.page_frame_number, h.coherency,
                             h.write_en, h.valid, g};
    endfunction : tesr_half_to_word

    function automatic tesr_pkg::tesr_half_t tesr_word_to_half(input logic [31:0] w);
        tesr_pkg::tesr_half_t h;
        h.page_frame_number = w[tesr_pkg::ENT_PFN_HI:tesr_pkg::ENT_PFN_LO];
        h.coherency = w[5:3];
        h.write_en = w[tesr_pkg::ENT_WRITE_EN];
        h.valid = w[tesr_pkg::ENT_VALID];
        h.read_inh = w[tesr_pkg::ENT_READ_INH];
        h.exec_inh = w[tesr_pkg::ENT_EXEC_INH];
        tesr_word_to_half = h;
    endfunction : tesr_word_to_half

    // writable bits of an entry word, inhibit bits only when enabled
    function automatic logic [31:0] tesr_entry_wmask(input logic ri_en, input logic xi_en);
        tesr_entry_wmask = tesr_pkg::ENT_RW_MASK;
        tesr_entry_wmask[tesr_pkg::ENT_READ_INH] = ri_en;
        tesr_entry_wmask[tesr_pkg::ENT_EXEC_INH] = xi_en;
    endfunction : tesr_entry_wmask

    logic read_inhibit_enable;
    logic exec_inhibit_enable;
    logic tiny_page_enable;
    assign read_inhibit_enable = page_granularity_reg[tesr_pkg::GRAN_READ_INH_EN];
    assign exec_inhibit_enable = page_granularity_reg[tesr_pkg::GRAN_EXEC_INH_EN];
    assign tiny_page_enable = TINY_PAGE_CAPABLE
        & page_granularity_reg[tesr_pkg::GRAN_TINY_PAGE_EN];

    // ****************************************
    // register state
    // ****************************************
    logic [31:0] even_page_entry_reg, even_page_entry_next;
    logic [31:0] odd_page_entry_reg, odd_page_entry_next;
    logic [8:0] table_base_field_reg, table_base_field_next;
    logic [18:0] missed_vpage_pair_reg, missed_vpage_pair_next;
    logic [31:0] thread_scratch_reg, thread_scratch_next;
    logic [15:0] page_mask_reg, page_mask_next;
    logic [1:0] page_ext_reg, page_ext_next;
    logic [31:0] mfc_data_next;
    logic hw_rd_ok_next;
    logic [31:0] hw_rd_data_next;
    logic tlb_wr_en_next;
    tesr_pkg::tesr_entry_t tlb_wr_entry_next;
    logic [31:0] page_size_reg;
    logic [31:0] pte_pointer_word;
    logic [31:0] ent_wmask;

    assign page_size_reg = {3'h0, page_mask_reg,
                            tiny_page_enable ? page_ext_reg : 2'h0, 11'h000};
    assign pte_pointer_word = {table_base_field_reg, missed_vpage_pair_reg, 4'h0};
    assign ent_wmask = tesr_entry_wmask(read_inhibit_enable, exec_inhibit_enable);

    always_comb begin
        logic wr_even;
        logic wr_odd;
        logic wr_ptr;
        logic wr_scr;
        logic wr_psz;
        wr_even = mtc_en && mtc_reg == tesr_pkg::REG_EVEN_ENTRY && mtc_sel == tesr_pkg::SEL_ZERO;
        wr_odd = mtc_en && mtc_reg == tesr_pkg::REG_ODD_ENTRY && mtc_sel == tesr_pkg::SEL_ZERO;
        wr_ptr = mtc_en && mtc_reg == tesr_pkg::REG_PTE_PTR && mtc_sel == tesr_pkg::SEL_PTE_PTR;
        wr_scr = mtc_en && mtc_reg == tesr_pkg::REG_PTE_PTR && mtc_sel == tesr_pkg::SEL_SCRATCH;
        wr_psz = mtc_en && mtc_reg == tesr_pkg::REG_PAGE_SIZE
            && mtc_sel == tesr_pkg::SEL_PAGE_SIZE;
        even_page_entry_next = even_page_entry_reg;
        odd_page_entry_next = odd_page_entry_reg;
        table_base_field_next = table_base_field_reg;
        missed_vpage_pair_next = missed_vpage_pair_reg;
        thread_scratch_next = thread_scratch_reg;
        page_mask_next = page_mask_reg;
        page_ext_next = page_ext_reg;
        // tlb read loads the entry pair and page size, register moves to them otherwise
        if (tlb_read_instr) begin
            even_page_entry_next = tesr_half_to_word(tlb_rd_entry.even,
                                                     tlb_rd_entry.global_bit);
            odd_page_entry_next = tesr_half_to_word(tlb_rd_entry.odd,
                                                    tlb_rd_entry.global_bit);
            even_page_entry_next = even_page_entry_next & ent_wmask;
            odd_page_entry_next = odd_page_entry_next & ent_wmask;
            page_mask_next = tlb_rd_entry.mask[17:2];
            if (tiny_page_enable) begin
                page_ext_next = tlb_rd_entry.mask[1:0];
            end
        end else begin
            if (wr_even) begin
                even_page_entry_next = mtc_data & ent_wmask;
            end
            if (wr_odd) begin
                odd_page_entry_next = mtc_data & ent_wmask;
            end
            if (wr_psz) begin
                page_mask_next = mtc_data[28:13];
                if (tiny_page_enable) begin
                    page_ext_next = mtc_data[12:11];
                end
            end
        end
        if (wr_ptr) begin
            table_base_field_next = mtc_data[31:23];
        end
        if (wr_scr) begin
            thread_scratch_next = mtc_data;
        end
        // hardware capture; software write never reaches this field
        if (tlb_fault) begin
            missed_vpage_pair_next = fault_vaddr[31:13];
        end
    end

    always_comb begin
        mfc_data_next = 32'h0000_0000;
        unique case (mfc_reg)
            tesr_pkg::REG_EVEN_ENTRY: begin
                if (mfc_sel == tesr_pkg::SEL_ZERO) begin
                    mfc_data_next = even_page_entry_reg;
                end
            end
            tesr_pkg::REG_ODD_ENTRY: begin
                if (mfc_sel == tesr_pkg::SEL_ZERO) begin
                    mfc_data_next = odd_page_entry_reg;
                end
            end
            tesr_pkg::REG_PTE_PTR: begin
                if (mfc_sel == tesr_pkg::SEL_PTE_PTR) begin
                    mfc_data_next = pte_pointer_word;
                end else if (mfc_sel == tesr_pkg::SEL_SCRATCH) begin
                    mfc_data_next = thread_scratch_reg;
                end
            end
            tesr_pkg::REG_PAGE_SIZE: begin
                if (mfc_sel == tesr_pkg::SEL_PAGE_SIZE) begin
                    mfc_data_next = page_size_reg;
                end
            end
            default: begin
                mfc_data_next = 32'h0000_0000;
            end
        endcase
        // unprivileged read of scratch through the gate
        hw_rd_ok_next = hw_rd_index == tesr_pkg::USER_LOCAL_HW_INDEX
            && hw_reg_access_gate[tesr_pkg::GATE_USER_LOCAL];
        hw_rd_data_next = hw_rd_ok_next ? thread_scratch_reg : 32'h0000_0000;
        // tlb write image
        tlb_wr_en_next = tlb_indexed_write | tlb_random_write;
        tlb_wr_entry_next.even = tesr_word_to_half(even_page_entry_reg);
        tlb_wr_entry_next.odd = tesr_word_to_half(odd_page_entry_reg);
        tlb_wr_entry_next.global_bit = even_page_entry_reg[tesr_pkg::ENT_GLOBAL]
            & odd_page_entry_reg[tesr_pkg::ENT_GLOBAL];
        tlb_wr_entry_next.mask = {page_mask_reg,
            tiny_page_enable ? page_ext_reg : tesr_pkg::PSZ_EXT_DISABLED};
    end

    // ****************************************
    // page check for a matched half
    // ****************************************
    logic asid_match_next;
    logic invalid_next;
    logic modified_next;
    logic [31:0] paddr_next;
    logic [2:0] policy_next;
    logic [17:0] match_ext_next;

    always_comb begin
        asid_match_next = chk_global || chk_entry_asid == chk_cur_asid;
        invalid_next = (|chk_access && !chk_half.valid)
            || (chk_access.load && read_inhibit_enable && chk_half.read_inh)
            || (chk_access.fetch && exec_inhibit_enable && chk_half.exec_inh);
        modified_next = chk_access.store && chk_half.valid && !chk_half.write_en;
        if (tiny_page_enable) begin
            paddr_next = {2'h0, chk_half.page_frame_number, chk_vaddr[9:0]};
        end else begin
            paddr_next = {chk_half.page_frame_number, chk_vaddr[11:0]};
        end
        unique case (chk_half.coherency)
            tesr_pkg::COH_WT_NOALLOC: policy_next = tesr_pkg::COH_WT_NOALLOC;
            tesr_pkg::COH_WT_ALLOC: policy_next = tesr_pkg::COH_WT_ALLOC;
            tesr_pkg::COH_UNCACHED,
            tesr_pkg::COH_UNCACHED_ALIAS: policy_next = tesr_pkg::COH_UNCACHED;
            default: policy_next = tesr_pkg::COH_WB_ALLOC;
        endcase
        match_ext_next = tlb_wr_entry_next.mask;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            even_page_entry_reg <= 32'h0000_0000;
            odd_page_entry_reg <= 32'h0000_0000;
            table_base_field_reg <= 9'h000;
            missed_vpage_pair_reg <= 19'h00000;
            thread_scratch_reg <= 32'h0000_0000;
            page_mask_reg <= 16'h0000;
            page_ext_reg <= 2'h0;
            mfc_data <= 32'h0000_0000;
            hw_rd_ok <= 1'b0;
            hw_rd_data <= 32'h0000_0000;
            tlb_wr_en <= 1'b0;
            tlb_wr_entry <= '0;
            chk_asid_match <= 1'b0;
            chk_invalid_fault <= 1'b0;
            chk_modified_fault <= 1'b0;
            chk_paddr <= 32'h0000_0000;
            chk_cache_policy <= 3'h0;
            match_ignore_ext <= 18'h00000;
        end else begin
            even_page_entry_reg <= even_page_entry_next;
            odd_page_entry_reg <= odd_page_entry_next;
            table_base_field_reg <= table_base_field_next;
            missed_vpage_pair_reg <= missed_vpage_pair_next;
            thread_scratch_reg <= thread_scratch_next;
            page_mask_reg <= page_mask_next;
            page_ext_reg <= page_ext_next;
            mfc_data <= mfc_data_next;
            hw_rd_ok <= hw_rd_ok_next;
            hw_rd_data <= hw_rd_data_next;
            tlb_wr_en <= tlb_wr_en_next;
            tlb_wr_entry <= tlb_wr_entry_next;
            chk_asid_match <= asid_match_next;
            chk_invalid_fault <= invalid_next;
            chk_modified_fault <= modified_next;
            chk_paddr <= paddr_next;
            chk_cache_policy <= policy_next;
            match_ignore_ext <= match_ext_next;
        end
    end
endmodule : tesr_regs

// ### tesr_regs_sva.sv
// assertions on the staging register ports
`timescale 1ns/100ps
module tesr_regs_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic mtc_en,
    input wire logic [4:0] mfc_reg,
    input wire logic [2:0] mfc_sel,
    input wire logic [31:0] mfc_data,
    input wire logic [4:0] hw_rd_index,
    input wire logic [31:0] hw_reg_access_gate,
    input wire logic hw_rd_ok,
    input wire logic [31:0] page_granularity_reg,
    input wire logic tlb_read_instr,
    input wire tesr_pkg::tesr_entry_t tlb_rd_entry,
    input wire logic tlb_indexed_write,
    input wire logic tlb_random_write,
    input wire logic tlb_wr_en,
    input wire tesr_pkg::tesr_half_t chk_half,
    input wire tesr_pkg::tesr_access_t chk_access,
    input wire logic chk_global,
    input wire logic [31:0] chk_vaddr,
    input wire logic chk_asid_match,
    input wire logic chk_invalid_fault,
    input wire logic chk_modified_fault,
    input wire logic [31:0] chk_paddr,
    input wire logic [2:0] chk_cache_policy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // ****************************************
    // sequences and properties
    // ****************************************
    sequence s_wr_req;
        tlb_indexed_write || tlb_random_write;
    endsequence
    sequence s_rd_even;
        tlb_read_instr ##1 (mfc_reg == tesr_pkg::REG_EVEN_ENTRY && mfc_sel == 3'h0 && !mtc_en
            && !tlb_read_instr);
    endsequence
    AST_WR_PULSE: assert property (s_wr_req |=> tlb_wr_en ##1 (!tlb_wr_en
        || $past(tlb_indexed_write || tlb_random_write)))
        else $error("array write strobe wrong");
    AST_RD_GLOBAL: assert property (s_rd_even |=> mfc_data[0] == $past(tlb_rd_entry.global_bit, 2))
        else $error("global bit not copied on array read");
    AST_HW_GATE: assert property (1'b1 |=> hw_rd_ok == $past(hw_rd_index == 5'h1d
        && hw_reg_access_gate[29]))
        else $error("scratch hw read gate wrong");
    AST_COH_ALIAS: assert property (chk_half.coherency > 3'h3 |=>
        chk_cache_policy == ($past(chk_half.coherency) == 3'h7 ? 3'h2 : 3'h3))
        else $error("coherency alias wrong");
    AST_MOD_FAULT: assert property (chk_access.store && chk_half.valid |=>
        chk_modified_fault == !$past(chk_half.write_en))
        else $error("modified fault wrong");
    AST_PADDR: assert property (!page_granularity_reg[28] |=>
        chk_paddr == {$past(chk_half.page_frame_number), $past(chk_vaddr[11:0])})
        else $error("physical address wrong");
    AST_INVALID: assert property (chk_access != 3'h0 && !chk_half.valid |=> chk_invalid_fault)
        else $error("invalid fault missing");
    AST_PTR_LOW: assert property (mfc_reg == 5'h04 && mfc_sel == 3'h0 |=> mfc_data[3:0] == 4'h0)
        else $error("pointer low bits not zero");
    AST_PSZ_ZERO: assert property (mfc_reg == 5'h05 && mfc_sel == 3'h0 |=>
        mfc_data[31:29] == 3'h0 && mfc_data[10:0] == 11'h0)
        else $error("page size reserved bits not zero");
    AST_ASID_SKIP: assert property (chk_global |=> chk_asid_match)
        else $error("global entry asid not skipped");
endmodule : tesr_regs_sva

bind tesr_regs tesr_regs_sva u_sva (
    .clock, .srst, .mtc_en, .mfc_reg, .mfc_sel, .mfc_data, .hw_rd_index, .hw_reg_access_gate,
    .hw_rd_ok, .page_granularity_reg, .tlb_read_instr, .tlb_rd_entry, .tlb_indexed_write,
    .tlb_random_write, .tlb_wr_en, .chk_half, .chk_access, .chk_global, .chk_vaddr,
    .chk_asid_match, .chk_invalid_fault, .chk_modified_fault, .chk_paddr, .chk_cache_policy
);

// ### testbench.sv
// self-checking bench for the staging register group
`timescale 1ns/100ps
module testbench;
    logic clock, srst, mtc_en, tlb_read_instr, tlb_indexed_write, tlb_random_write, tlb_fault;
    logic chk_global, hw_rd_ok, tlb_wr_en, chk_asid_match, chk_invalid_fault, chk_modified_fault;
    logic gl;
    logic [4:0] mtc_reg, mfc_reg, hw_rd_index;
    logic [2:0] mtc_sel, mfc_sel, chk_cache_policy;
    logic [31:0] mtc_data, mfc_data, hw_reg_access_gate, hw_rd_data, page_granularity_reg;
    logic [31:0] fault_vaddr, chk_vaddr, chk_paddr, d, e, g, r, gv, psz;
    logic [7:0] chk_entry_asid, chk_cur_asid, ea, ca;
    logic [17:0] match_ignore_ext, m;
    tesr_pkg::tesr_entry_t tlb_rd_entry, tlb_wr_entry;
    tesr_pkg::tesr_half_t chk_half, h;
    tesr_pkg::tesr_access_t chk_access, a;
    int error_cnt, tests_run;

    tesr_regs #(.TINY_PAGE_CAPABLE(1'b1)) dut (.*);
    tesr_array_model u_array (.clock(clock), .srst(srst), .tlb_wr_en(tlb_wr_en),
        .tlb_wr_entry(tlb_wr_entry), .tlb_rd_entry(tlb_rd_entry));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ****************************************
    // tasks and expectations
    // ****************************************
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] rg, input logic [2:0] sl, input logic [31:0] dt);
        @(posedge clock);
        mtc_en <= 1'b1;
        mtc_reg <= rg;
        mtc_sel <= sl;
        mtc_data <= dt;
        @(posedge clock);
        mtc_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] rg, input logic [2:0] sl, output logic [31:0] dt);
        @(posedge clock);
        mfc_reg <= rg;
        mfc_sel <= sl;
        @(posedge clock);
        #1;
        dt = mfc_data;
    endtask : rd
    function automatic logic [31:0] ent_exp(input logic [31:0] dt, input logic [31:0] gr);
        return (dt & tesr_pkg::ENT_RW_MASK) | (dt & {gr[31:30], 30'h0});
    endfunction : ent_exp
    function automatic logic [5:0] page_exp(input tesr_pkg::tesr_half_t hh,
        input tesr_pkg::tesr_access_t aa, input logic [31:0] gr, input logic gg, input logic eq);
        logic [2:0] pol;
        pol = (hh.coherency == 3'h7) ? 3'h2 : (hh.coherency > 3'h3) ? 3'h3 : hh.coherency;
        return {gg | eq, ((aa.fetch | aa.load | aa.store) & !hh.valid)
            | (aa.load & gr[31] & hh.read_inh) | (aa.fetch & gr[30] & hh.exec_inh),
            aa.store & hh.valid & !hh.write_en, pol};
    endfunction : page_exp
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("unexpected at %0t: run hung", $time);
        test_done();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(10688));
        srst = 1'b1;
        {mtc_en, tlb_read_instr, tlb_indexed_write, tlb_random_write, tlb_fault, chk_global} = '0;
        {mtc_reg, mtc_sel, mfc_reg, mfc_sel, hw_rd_index, chk_entry_asid, chk_cur_asid} = '0;
        {mtc_data, hw_reg_access_gate, page_granularity_reg, fault_vaddr, chk_vaddr} = '0;
        chk_half = '0;
        chk_access = '0;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(i < 5 ? 5'(i < 3 ? i + 2 : i + 1) : 5'h07, i == 3 ? 3'h2 : 3'h0, r);
            chk(r, 32'h0);
        end
        $display("reset and unmapped reads done");
        for (int i = 0; i < 16; i++) begin
            gv = $urandom;
            d = $urandom;
            page_granularity_reg <= gv;
            wr(i[0] ? tesr_pkg::REG_ODD_ENTRY : tesr_pkg::REG_EVEN_ENTRY, tesr_pkg::SEL_ZERO, d);
            rd(i[0] ? tesr_pkg::REG_ODD_ENTRY : tesr_pkg::REG_EVEN_ENTRY, tesr_pkg::SEL_ZERO, r);
            chk(r, ent_exp(d, gv));
        end
        $display("entry register writes done");
        d = $urandom;
        wr(tesr_pkg::REG_PTE_PTR, tesr_pkg::SEL_PTE_PTR, d);
        rd(tesr_pkg::REG_PTE_PTR, tesr_pkg::SEL_PTE_PTR, r);
        chk(r, d & tesr_pkg::PTE_BASE_MASK);
        g = $urandom;
        @(posedge clock);
        tlb_fault <= 1'b1;
        fault_vaddr <= g;
        @(posedge clock);
        tlb_fault <= 1'b0;
        rd(tesr_pkg::REG_PTE_PTR, tesr_pkg::SEL_PTE_PTR, r);
        chk(r, (d & tesr_pkg::PTE_BASE_MASK) | {9'h0, g[31:13], 4'h0});
        wr(tesr_pkg::REG_PTE_PTR, tesr_pkg::SEL_SCRATCH, d);
        rd(tesr_pkg::REG_PTE_PTR, tesr_pkg::SEL_SCRATCH, r);
        chk(r, d);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            hw_rd_index <= k[0] ? tesr_pkg::USER_LOCAL_HW_INDEX : 5'h1c;
            hw_reg_access_gate <= k[1] ? 32'h2000_0000 : 32'hdfff_ffff;
            @(posedge clock);
            #1;
            chk({31'h0, hw_rd_ok}, {31'h0, k == 3});
            chk(hw_rd_data, k == 3 ? d : 32'h0);
        end
        $display("pointer and scratch done");
        for (int i = 0; i < 16; i++) begin
            d = (i < 8) ? $urandom : ((32'h4 << (2 * (i - 8))) - 32'h1) << 11;
            page_granularity_reg <= {3'h0, i[0], 28'h0};
            wr(tesr_pkg::REG_PAGE_SIZE, tesr_pkg::SEL_PAGE_SIZE, d);
            rd(tesr_pkg::REG_PAGE_SIZE, tesr_pkg::SEL_PAGE_SIZE, r);
            psz = d & (tesr_pkg::PSZ_MASK_FIELD | (i[0] ? tesr_pkg::PSZ_EXT_FIELD : 32'h0));
            chk(r, psz);
            m = {psz[28:13], i[0] ? psz[12:11] : tesr_pkg::PSZ_EXT_DISABLED};
            g = ($urandom & 32'hffff_fffe) | {31'h0, i[1]};
            e = ($urandom & 32'hffff_fffe) | {31'h0, i[2]};
            wr(tesr_pkg::REG_EVEN_ENTRY, tesr_pkg::SEL_ZERO, g);
            wr(tesr_pkg::REG_ODD_ENTRY, tesr_pkg::SEL_ZERO, e);
            @(posedge clock);
            tlb_indexed_write <= i[3];
            tlb_random_write <= !i[3];
            @(posedge clock);
            tlb_indexed_write <= 1'b0;
            tlb_random_write <= 1'b0;
            #1;
            chk({31'h0, tlb_wr_en}, 32'h1);
            chk({31'h0, tlb_wr_entry.global_bit}, {31'h0, g[0] & e[0]});
            chk({12'h0, tlb_wr_entry.even.page_frame_number}, {12'h0, g[25:6]});
            chk({12'h0, tlb_wr_entry.odd.page_frame_number}, {12'h0, e[25:6]});
            chk({14'h0, tlb_wr_entry.mask}, {14'h0, m});
            chk({14'h0, match_ignore_ext}, {14'h0, m});
            @(posedge clock);
            tlb_read_instr <= 1'b1;
            mfc_reg <= tesr_pkg::REG_EVEN_ENTRY;
            mfc_sel <= tesr_pkg::SEL_ZERO;
            @(posedge clock);
            tlb_read_instr <= 1'b0;
            rd(tesr_pkg::REG_EVEN_ENTRY, tesr_pkg::SEL_ZERO, r);
            chk(r, {g[31:1] & 31'h01ff_ffff, g[0] & e[0]});
            rd(tesr_pkg::REG_ODD_ENTRY, tesr_pkg::SEL_ZERO, r);
            chk(r, {e[31:1] & 31'h01ff_ffff, g[0] & e[0]});
            rd(tesr_pkg::REG_PAGE_SIZE, tesr_pkg::SEL_PAGE_SIZE, r);
            chk(r, psz);
        end
        $display("page size and array transfer done");
        for (int k = 0; k < 24; k++) begin
            {h, a} = 30'($urandom);
            {ea, ca, gl} = 17'($urandom);
            h.coherency = k[2:0];
            ca = k[3] ? ea : ca;
            gv = $urandom;
            d = $urandom;
            @(posedge clock);
            page_granularity_reg <= gv;
            chk_half <= h;
            chk_access <= a;
            chk_global <= gl;
            chk_entry_asid <= ea;
            chk_cur_asid <= ca;
            chk_vaddr <= d;
            @(posedge clock);
            #1;
            chk({26'h0, chk_asid_match, chk_invalid_fault, chk_modified_fault, chk_cache_policy},
                {26'h0, page_exp(h, a, gv, gl, ea == ca)});
            chk(chk_paddr, gv[28] ? {2'h0, h.page_frame_number, d[9:0]} : {h.page_frame_number, d[11:0]});
        end
        $display("page check done");
        test_done();
    end
endmodule : testbench
